// File: rtl/bsl_bit_sync_loop.sv
`timescale 1ns/1ns
`default_nettype none

module bsl_bit_sync_loop
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   input  wire logic                  spi_sclk,
   input  wire logic                  spi_cs_n,
   input  wire logic                  spi_si,
   output logic                       spi_so,
   output logic                       spi_so_oe,
   input  wire logic                  sync_found,
   input  wire logic                  carrier_sense,
   input  wire logic signed [7:0]     phase_err,
   input  wire logic                  phase_err_valid,
   output logic signed [15:0]         rate_offset,
   output logic signed [15:0]         timing_correction,
   output logic                       correction_valid,
   output logic                       loop_frozen
);

   logic                              rst_meta_reg, rst_n;
   bsl_pkg::bsl_bit_sync_s            bit_sync_config_reg;
   logic [7:0]                        freq_ofs_cfg_reg;
   bsl_pkg::bsl_reg_wr_s              wr;
   logic [bsl_pkg::ADDR_W-1:0]        rd_addr;
   logic [7:0]                        rd_data;
   logic [3:0]                        ki_half;
   logic [2:0]                        kp;
   logic signed [15:0]                lim, integ_next, corr_next;
   logic signed [17:0]                i_step, p_term;
   logic                              update;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic signed [15:0] sat(input logic signed [17:0] v,
                                              input logic signed [15:0] l);
      logic signed [17:0] hi;
      hi = {{2{l[15]}}, l};
      if (v > hi)
         sat = l;
      else if (v < -hi)
         sat = -l;
      else
         sat = v[15:0];
   endfunction

   function automatic logic signed [15:0] rate_limit(input logic [1:0] code);
      case (code)
         2'b01:   rate_limit = bsl_pkg::RATE_LIM_3P1;
         2'b10:   rate_limit = bsl_pkg::RATE_LIM_6P2;
         2'b11:   rate_limit = bsl_pkg::RATE_LIM_12P5;
         default: rate_limit = bsl_pkg::RATE_LIM_OFF;
      endcase
   endfunction

   function automatic logic signed [17:0] mul(input logic signed [7:0] e,
                                              input logic [3:0] g);
      mul = $signed({{10{e[7]}}, e}) * $signed({14'h0000, g});
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Serial register port
   // ------------------------------------------------------------
   bsl_spi_slave u_spi
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .spi_sclk  (spi_sclk),
      .spi_cs_n  (spi_cs_n),
      .spi_si    (spi_si),
      .rd_data   (rd_data),
      .rd_addr   (rd_addr),
      .wr        (wr),
      .spi_so    (spi_so),
      .spi_so_oe (spi_so_oe)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_sync_config_reg <= bsl_pkg::BIT_SYNC_RESET;
         freq_ofs_cfg_reg    <= bsl_pkg::FREQ_OFS_RESET;
      end
      else if (ce && wr.wr)
      begin
         if (wr.addr == bsl_pkg::ADDR_BIT_SYNC_CFG)
            bit_sync_config_reg <= wr.data;
         if (wr.addr == bsl_pkg::ADDR_FREQ_OFS_CFG)
            freq_ofs_cfg_reg <= wr.data;
      end
   end

   always_comb
   begin
      case (rd_addr)
         bsl_pkg::ADDR_BIT_SYNC_CFG: rd_data = bit_sync_config_reg;
         bsl_pkg::ADDR_FREQ_OFS_CFG: rd_data = freq_ofs_cfg_reg;
         default:                    rd_data = bsl_pkg::READ_UNMAPPED;
      endcase
   end

   // ------------------------------------------------------------
   // Gain selection and loop arithmetic
   // ------------------------------------------------------------
   always_comb
   begin
      // Integral gain in units of K_I/2 so the post-sync half gain stays exact
      ki_half = {1'b0, {1'b0, bit_sync_config_reg.presync_integral_gain} + 3'h1}
                << 1;
      if (sync_found && bit_sync_config_reg.postsync_integral_gain_sel)
         ki_half = bsl_pkg::KI_HALF_POST;
      kp = {1'b0, bit_sync_config_reg.presync_proportional_gain} + 3'h1;
      if (sync_found && bit_sync_config_reg.postsync_proportional_gain_sel)
         kp = bsl_pkg::KP_POST;
      lim        = rate_limit(bit_sync_config_reg.rate_offset_saturation);
      i_step     = mul(phase_err, ki_half) >>> 1;
      p_term     = mul(phase_err, {1'b0, kp});
      integ_next = sat({{2{rate_offset[15]}}, rate_offset} + i_step, lim);
      corr_next  = sat(p_term + {{2{integ_next[15]}}, integ_next}, bsl_pkg::CORR_MAX);
   end

   assign update = phase_err_valid & ~loop_frozen;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         loop_frozen <= 1'b0;
      else if (ce)
         loop_frozen <= freq_ofs_cfg_reg[bsl_pkg::GATE_BIT] & ~carrier_sense;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rate_offset       <= bsl_pkg::RATE_LIM_OFF;
         timing_correction <= bsl_pkg::RATE_LIM_OFF;
         correction_valid  <= 1'b0;
      end
      else if (ce)
      begin
         correction_valid <= update;
         if (lim == bsl_pkg::RATE_LIM_OFF)
            rate_offset <= bsl_pkg::RATE_LIM_OFF;
         else if (update)
            rate_offset <= integ_next;
         else
            // A lowered limit clamps the held offset at once, not at the next sample
            rate_offset <= sat({{2{rate_offset[15]}}, rate_offset}, lim);
         if (update)
            timing_correction <= corr_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_cfg_write;
      ce && wr.wr && wr.addr == bsl_pkg::ADDR_BIT_SYNC_CFG;
   endsequence

   a_cfg_write_read: assert property (s_cfg_write ##1 (rd_addr == bsl_pkg::ADDR_BIT_SYNC_CFG)
      |-> rd_data == $past(wr.data, 1))
      else $error("bit sync register did not read back the written value");
   a_post_ki_half: assert property (sync_found && bit_sync_config_reg[3] |-> ki_half == 4'h1)
      else $error("post-sync integral gain is not half");
   a_pre_ki_scale: assert property (!sync_found |-> ki_half ==
      4'((bit_sync_config_reg[7:6] + 3'h1) * 2))
      else $error("pre-sync integral gain wrong");
   a_post_kp_keep: assert property (sync_found && !bit_sync_config_reg[2] |->
      kp == 3'(bit_sync_config_reg[5:4] + 3'h1))
      else $error("post-sync proportional gain does not follow pre-sync");
   a_pre_kp_scale: assert property (!sync_found |-> kp == 3'(bit_sync_config_reg[5:4] + 3'h1))
      else $error("pre-sync proportional gain wrong");
   a_limit_off_zero: assert property (ce && bit_sync_config_reg[1:0] == 2'b00
      |=> rate_offset == 16'sh0000)
      else $error("rate offset not cleared while compensation disabled");
   a_limit_bound: assert property ($stable(lim) [*2] |-> rate_offset <= lim && rate_offset >= -lim)
      else $error("rate offset beyond saturation limit");
   a_freeze_cause: assert property (ce |=> loop_frozen ==
      $past(freq_ofs_cfg_reg[5] && !carrier_sense))
      else $error("freeze does not follow gate and carrier sense");
   a_frozen_hold: assert property (loop_frozen && $stable(lim) ##1 loop_frozen && $stable(lim)
      |-> $stable(rate_offset) && !correction_valid)
      else $error("loop moved while frozen");
   a_integ_track: assert property (ce && update && lim != 16'sh0000 |=> rate_offset ==
      $past(integ_next))
      else $error("integral path did not update rate offset");

endmodule

`default_nettype wire

// File: rtl/bsl_pkg.sv
package bsl_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int            ADDR_W             = 6;
   localparam logic [5:0]    ADDR_FREQ_OFS_CFG  = 6'h19;
   localparam logic [5:0]    ADDR_BIT_SYNC_CFG  = 6'h1a;
   localparam logic [7:0]    BIT_SYNC_RESET     = 8'h6c;
   localparam logic [7:0]    FREQ_OFS_RESET     = 8'h36;
   localparam int            GATE_BIT           = 5;
   localparam logic [7:0]    READ_UNMAPPED      = 8'h00;

   // ------------------------------------------------------------
   // Serial port framing
   // ------------------------------------------------------------
   localparam int            RW_BIT             = 7;
   localparam logic [3:0]    LAST_BIT           = 4'h7;

   // ------------------------------------------------------------
   // Loop arithmetic
   // ------------------------------------------------------------
   // Rate offset word: 0x8000 stands for 100 percent of the data rate
   localparam logic signed [15:0] RATE_LIM_OFF  = 16'sh0000;
   localparam logic signed [15:0] RATE_LIM_3P1  = 16'sh0400;
   localparam logic signed [15:0] RATE_LIM_6P2  = 16'sh0800;
   localparam logic signed [15:0] RATE_LIM_12P5 = 16'sh1000;
   localparam logic signed [15:0] CORR_MAX      = 16'sh7fff;
   localparam logic [3:0]    KI_HALF_POST       = 4'h1;
   localparam logic [2:0]    KP_POST            = 3'h1;

   typedef struct packed
   {
      logic [1:0] presync_integral_gain;
      logic [1:0] presync_proportional_gain;
      logic       postsync_integral_gain_sel;
      logic       postsync_proportional_gain_sel;
      logic [1:0] rate_offset_saturation;
   } bsl_bit_sync_s;

   typedef struct packed
   {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } bsl_reg_wr_s;

   typedef enum logic [1:0]
   {
      SPI_IDLE   = 2'b00,
      SPI_HEADER = 2'b01,
      SPI_DATA   = 2'b11,
      SPI_DONE   = 2'b10
   } bsl_spi_state_e;

endpackage

// File: rtl/bsl_spi_slave.sv
`timescale 1ns/1ns
`default_nettype none

module bsl_spi_slave
(
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic                            ce,
   input  wire logic                            spi_sclk,
   input  wire logic                            spi_cs_n,
   input  wire logic                            spi_si,
   input  wire logic [7:0]                      rd_data,
   output logic [bsl_pkg::ADDR_W-1:0]           rd_addr,
   output bsl_pkg::bsl_reg_wr_s                 wr,
   output logic                                 spi_so,
   output logic                                 spi_so_oe
);

   logic [2:0]              sclk_meta_reg, sclk_sync_reg;
   logic                    sclk_prev_reg;
   logic [7:0]              in_shift_reg;
   logic [7:0]              out_shift_reg;
   logic [3:0]              bit_cnt_reg;
   logic                    is_read_reg;
   bsl_pkg::bsl_spi_state_e state_reg;
   logic                    rise, fall, cs_n_s, si_s;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Reset to the idle pin levels (clock low, select high) so no false edge follows
         sclk_meta_reg <= 3'h3;
         sclk_sync_reg <= 3'h3;
         sclk_prev_reg <= 1'b0;
      end
      else if (ce)
      begin
         sclk_meta_reg <= {spi_sclk, spi_cs_n, spi_si};
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg[2];
      end
   end

   assign cs_n_s = sclk_sync_reg[1];
   assign si_s   = sclk_sync_reg[0];
   assign rise   = sclk_sync_reg[2] & ~sclk_prev_reg;
   assign fall   = ~sclk_sync_reg[2] & sclk_prev_reg;

   // ------------------------------------------------------------
   // Frame: header byte (read flag, address), then one data byte
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg    <= bsl_pkg::SPI_IDLE;
         bit_cnt_reg  <= 4'h0;
         in_shift_reg <= 8'h00;
         is_read_reg  <= 1'b0;
         rd_addr      <= '0;
         wr           <= '0;
      end
      else if (ce)
      begin
         wr.wr <= 1'b0;
         if (cs_n_s)
         begin
            state_reg   <= bsl_pkg::SPI_IDLE;
            bit_cnt_reg <= 4'h0;
         end
         else
         begin
            case (state_reg)
               bsl_pkg::SPI_IDLE:
                  state_reg <= bsl_pkg::SPI_HEADER;
               bsl_pkg::SPI_HEADER, bsl_pkg::SPI_DATA:
                  if (rise)
                  begin
                     in_shift_reg <= {in_shift_reg[6:0], si_s};
                     bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg == bsl_pkg::LAST_BIT)
                     begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == bsl_pkg::SPI_HEADER)
                        begin
                           is_read_reg <= in_shift_reg[bsl_pkg::RW_BIT-1];
                           rd_addr     <= {in_shift_reg[4:0], si_s};
                           state_reg   <= bsl_pkg::SPI_DATA;
                        end
                        else
                        begin
                           // Burst access is not supported; the frame ends here
                           wr.wr     <= ~is_read_reg;
                           wr.addr   <= rd_addr;
                           wr.data   <= {in_shift_reg[6:0], si_s};
                           state_reg <= bsl_pkg::SPI_DONE;
                        end
                     end
                  end
               bsl_pkg::SPI_DONE:
                  state_reg <= bsl_pkg::SPI_DONE;
               default:
                  state_reg <= bsl_pkg::SPI_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Read data out, changed on falling clock edges
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spi_so        <= 1'b0;
         spi_so_oe     <= 1'b0;
         out_shift_reg <= 8'h00;
      end
      else if (ce)
      begin
         spi_so_oe <= ~cs_n_s;
         if (cs_n_s || state_reg != bsl_pkg::SPI_DATA)
         begin
            if (fall || cs_n_s)
               spi_so <= 1'b0;
         end
         else if (fall && is_read_reg)
         begin
            if (bit_cnt_reg == 4'h0)
            begin
               spi_so        <= rd_data[7];
               out_shift_reg <= {rd_data[6:0], 1'b0};
            end
            else
            begin
               spi_so        <= out_shift_reg[7];
               out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

endmodule

`default_nettype wire

// File: verification/bsl_bit_sync_loop_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin errors++; $display("unexpected at %0t ns: got %h expected %h", $time, (act), (exp)); end end

module bsl_bit_sync_loop_tb;
   typedef struct packed
   {
      logic [7:0]  cfg;
      logic        sync;
      logic [7:0]  err;
      logic [15:0] rate;
      logic [15:0] corr;
   } bsl_row_s;

   localparam bsl_row_s ROWS [0:4] = '{
      '{8'h6c, 1'b0, 8'h0a, 16'h0000, 16'h001e},
      '{8'h6d, 1'b0, 8'h0a, 16'h0014, 16'h0032},
      '{8'h6d, 1'b1, 8'h0a, 16'h0005, 16'h000f},
      '{8'h01, 1'b1, 8'hf9, 16'hfff9, 16'hfff2},
      '{8'hf2, 1'b0, 8'h7f, 16'h01fc, 16'h03f8}};
   localparam logic signed [15:0] LIMS [1:3] = '{16'sh0400, 16'sh0800, 16'sh1000};

   logic                clk = 1'b0;
   logic                arst_n;
   logic                ce;
   logic                spi_sclk;
   logic                spi_cs_n;
   logic                spi_si;
   logic                spi_so;
   logic                spi_so_oe;
   logic                sync_found;
   logic                carrier_sense;
   logic signed [7:0]   phase_err;
   logic                phase_err_valid;
   logic signed [15:0]  rate_offset;
   logic signed [15:0]  timing_correction;
   logic                correction_valid;
   logic                loop_frozen;
   logic [7:0]          rd;
   logic signed [15:0]  lim;
   bsl_row_s            row;
   int                  errors = 0;
   int                  check_count = 0;
   int                  cycles = 0;
   int                  cv_count = 0;
   int                  oe_count = 0;

   always #20 clk = ~clk;

   bsl_bit_sync_loop bsl_bit_sync_loop_inst
   (
      .clk               (clk),
      .arst_n            (arst_n),
      .ce                (ce),
      .spi_sclk          (spi_sclk),
      .spi_cs_n          (spi_cs_n),
      .spi_si            (spi_si),
      .spi_so            (spi_so),
      .spi_so_oe         (spi_so_oe),
      .sync_found        (sync_found),
      .carrier_sense     (carrier_sense),
      .phase_err         (phase_err),
      .phase_err_valid   (phase_err_valid),
      .rate_offset       (rate_offset),
      .timing_correction (timing_correction),
      .correction_valid  (correction_valid),
      .loop_frozen       (loop_frozen)
   );

   bsl_spi_host bsl_spi_host_inst
   (
      .clk      (clk),
      .spi_so   (spi_so),
      .spi_sclk (spi_sclk),
      .spi_cs_n (spi_cs_n),
      .spi_si   (spi_si)
   );

   // ------------------------------------------------------------
   // Watchdog and result pulse counter
   // ------------------------------------------------------------
   // Sampled on the falling edge, where registered outputs have settled
   always @(negedge clk)
   begin
      cycles++;
      if (correction_valid === 1'b1)
         cv_count++;
      if (spi_so_oe === 1'b1)
         oe_count++;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] unused;
      bsl_spi_host_inst.xfer({2'b00, a}, d, unused);
   endtask

   task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
      bsl_spi_host_inst.xfer({2'b10, a}, 8'h00, d);
   endtask

   // Streams n samples back to back and counts the answers that come back
   task automatic feed(input logic [7:0] e, input int n, input int answers);
      int base;
      base = cv_count;
      repeat (n)
      begin
         @(negedge clk);
         phase_err       = e;
         phase_err_valid = 1'b1;
      end
      @(negedge clk);
      phase_err_valid = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(cv_count - base, answers)
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      arst_n          = 1'b0;
      ce              = 1'b1;
      sync_found      = 1'b0;
      carrier_sense   = 1'b0;
      phase_err       = 8'h00;
      phase_err_valid = 1'b0;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(spi_so_oe, 1'b0)
      `CHK(loop_frozen, 1'b1)
      reg_rd(6'h1a, rd);
      `CHK(rd, 8'h6c)
      `CHK(oe_count > 100, 1'b1)
      reg_rd(6'h19, rd);
      `CHK(rd, 8'h36)
      feed(8'h10, 1, 0);
      carrier_sense = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(loop_frozen, 1'b0)
      carrier_sense = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(loop_frozen, 1'b1)
      reg_wr(6'h19, 8'h16);
      repeat (2) @(negedge clk);
      `CHK(loop_frozen, 1'b0)
      reg_wr(6'h20, 8'h5a);
      reg_rd(6'h20, rd);
      `CHK(rd, 8'h00)
      reg_rd(6'h1a, rd);
      `CHK(rd, 8'h6c)
      // Limit code 0 clears the integral state before each row
      for (int i = 0; i < 5; i++)
      begin
         row        = ROWS[i];
         sync_found = 1'b0;
         reg_wr(6'h1a, row.cfg & 8'hfc);
         reg_wr(6'h1a, row.cfg);
         reg_rd(6'h1a, rd);
         `CHK(rd, row.cfg)
         sync_found = row.sync;
         feed(row.err, 1, 1);
         `CHK(rate_offset, row.rate)
         `CHK(timing_correction, row.corr)
      end
      sync_found = 1'b0;
      for (int c = 1; c <= 3; c++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            reg_wr(6'h1a, 8'hc0);
            reg_wr(6'h1a, 8'hc0 | 8'(c));
            feed(s ? 8'h80 : 8'h7f, 12, 12);
            lim = LIMS[c];
            `CHK(rate_offset, s ? -lim : lim)
         end
      end
      // Clock enable low must hold the loop still
      ce = 1'b0;
      feed(8'h7f, 4, 0);
      `CHK(rate_offset, -lim)
      ce = 1'b1;
      // Reset in mid-run clears the loop and restores the register
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(rate_offset, 16'sh0000)
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      reg_rd(6'h1a, rd);
      `CHK(rd, 8'h6c)
      wrap_up();
   end
endmodule

`undef CHK
`default_nettype wire

// File: verification/bsl_spi_host.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Host side of the register port: mode 0, MSB first
// ------------------------------------------------------------
module bsl_spi_host
(
   input  wire logic clk,
   input  wire logic spi_so,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_si
);
   // Each sclk phase lasts 5 clk so the two-flop pin sync always sees it
   localparam int PHASE = 5;

   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
   end

   task automatic xfer(input logic [7:0] hdr, input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] word;
      word  = {hdr, wdata};
      rdata = 8'h00;
      @(negedge clk);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_si = word[i];
         repeat (PHASE) @(negedge clk);
         spi_sclk = 1'b1;
         if (i < 8)
            rdata[i] = spi_so;
         repeat (PHASE) @(negedge clk);
         spi_sclk = 1'b0;
      end
      repeat (PHASE) @(negedge clk);
      spi_cs_n = 1'b1;
      // Released data line no longer holds the last bit
      spi_si = ~spi_si;
      repeat (PHASE) @(negedge clk);
   endtask
endmodule

`default_nettype wire
